// ===== core/gopt_pkg.sv
package gopt_pkg;

    // Clock.
    localparam int unsigned CLK_PERIOD_NS = 8;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] FRAME_REG_INDEX = 16'h1ffc;
    localparam logic [15:0] WD_REG_INDEX = 16'h1ffd;
    localparam logic [15:0] OPT_REG_INDEX = 16'h1ffe;
    localparam logic [15:0] FRAME_REG_ADDR = {FRAME_REG_INDEX[13:0], 2'b00};
    localparam logic [15:0] WD_REG_ADDR = {WD_REG_INDEX[13:0], 2'b00};
    localparam logic [15:0] OPT_REG_ADDR = {OPT_REG_INDEX[13:0], 2'b00};

    // Option bit positions, zero based (bit n of the option word is index n-1).
    localparam int unsigned OPT_WD_PORT1_BIT = 1;
    localparam int unsigned OPT_WD_PORT2_BIT = 2;
    localparam int unsigned OPT_RETAIN_BIT = 8;
    localparam int unsigned OPT_SWAP_BIT = 9;
    localparam logic [15:0] OPT_USED_MASK = 16'h0306;
    localparam logic [15:0] OPT_RESET = 16'h0000;

    // Watchdog timer.
    localparam logic [15:0] WD_RESET = 16'h0000;
    localparam int unsigned WD_TICK_NS = 1000000;
    localparam int unsigned WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;

    // Framing register layout of the first serial port.
    localparam int unsigned FRAME_BAUD_LSB = 0;
    localparam int unsigned FRAME_DATA_LSB = 16;
    localparam int unsigned FRAME_PARITY_LSB = 20;
    localparam int unsigned FRAME_STOP_LSB = 22;
    localparam int unsigned FRAME_MODE_LSB = 24;
    localparam logic [26:0] FRAME_USED_MASK = 27'h7ffffff;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_DUAL_SLAVE = 3'b001,
        MODE_HOST = 3'b010,
        MODE_PEER = 3'b011
    } port_mode_t;

    localparam logic [1:0] PARITY_NONE = 2'h0;
    localparam logic [1:0] PARITY_ODD = 2'h1;
    localparam logic [1:0] PARITY_EVEN = 2'h2;

    localparam logic [15:0] FACTORY_BAUD = 16'h2580;
    localparam logic [3:0] FACTORY_DATA_BITS = 4'h8;
    localparam logic [1:0] FACTORY_STOP_BITS = 2'h1;
    localparam logic [31:0] FRAME_RESET = {5'h00, MODE_DUAL_SLAVE, FACTORY_STOP_BITS,
                                           PARITY_EVEN, FACTORY_DATA_BITS, FACTORY_BAUD};

endpackage

// ===== core/sync3.sv
`timescale 1ns/10ps
module sync3 (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous level in, filtered level out.
    input wire logic async_i,
    output logic level_o
);
    logic s1_q, s2_q, s3_q, level_q;
    logic level_d;

    // A change counts only once the second and third stages agree.
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule

// ===== core/bit_swap.sv
`timescale 1ns/10ps
module bit_swap #(
    parameter int unsigned WIDTH = 16
) (
    // Word in, optionally mirrored word out.
    input wire logic swap_i,
    input wire logic [WIDTH-1:0] word_i,
    output logic [WIDTH-1:0] word_o
);
    logic [WIDTH-1:0] mirror;

    for (genvar i = 0; i < WIDTH; i++) begin : g_mirror
        assign mirror[i] = word_i[WIDTH-1-i];
    end

    assign word_o = swap_i ? mirror : word_i;
endmodule

// ===== core/global_options_register.sv
`timescale 1ns/10ps
// Behaviour
// - Option bit 2 set gates port 1 auto-polling by the watchdog timer.
// - Option bit 3 set gates port 2 auto-polling by the watchdog timer.
// - Option bit 9 set keeps rack registers at power-up; clear zeroes them.
// - Option bit 10 set presents rack input and holding words bit-reversed.
// - Every option bit is clear after reset.
// - Serial transmission proceeds only while clear-to-send is held high.
// - After factory reset port 1 runs dual slave, 9600 baud, 8E1.
module global_options_register #(
    parameter int unsigned WD_TICK_CYCLES_P = gopt_pkg::WD_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic [15:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // Auto-poll enables, one per serial port.
    output logic [1:0] autopoll_en_o,
    // Rack-addressed register store.
    input wire logic power_up_i,
    output logic rack_retain_o,
    output logic rack_zero_o,
    input wire logic [15:0] rack_in_i,
    output logic [15:0] rack_out_o,
    // RS-232 transmit path.
    input wire logic cts_i,
    input wire logic tx_i,
    output logic tx_o,
    output logic tx_allowed_o,
    // First serial port framing.
    input wire logic factory_reset_i,
    output logic [15:0] port1_baud_o,
    output logic [3:0] port1_data_bits_o,
    output logic [1:0] port1_parity_o,
    output logic [1:0] port1_stop_bits_o,
    output gopt_pkg::port_mode_t port1_mode_o
);
    import gopt_pkg::*;

    // Bus slave state.
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic req, wr_fire, hit_opt, hit_wd, hit_frame;

    // Configuration state.
    logic [15:0] opt_q, opt_d;
    logic [15:0] wd_q, wd_d;
    logic [31:0] frame_q, frame_d;
    logic [16:0] tick_cnt_q, tick_cnt_d;
    logic tick;

    // Datapath state.
    logic [1:0] poll_q, poll_d;
    logic zero_q, zero_d;
    logic [15:0] rack_q, rack_d;
    logic [15:0] rack_mux;
    logic tx_q, tx_d;
    logic cts_ok;

    assign req = cyc_i & stb_i;
    assign hit_opt = adr_i == OPT_REG_ADDR;
    assign hit_wd = adr_i == WD_REG_ADDR;
    assign hit_frame = adr_i == FRAME_REG_ADDR;
    // A write lands at the edge where the master samples ack high.
    assign wr_fire = req & we_i & ack_q;

    // Bus handshake: one wait cycle, ack for exactly one cycle.
    always_comb begin
        ack_d = req & ~ack_q;
        dat_d = dat_q;
        if (req && !ack_q) begin
            if (hit_opt) begin
                dat_d = {16'h0000, opt_q};
            end else if (hit_wd) begin
                dat_d = {16'h0000, wd_q};
            end else if (hit_frame) begin
                dat_d = frame_q;
            end else begin
                dat_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // Watchdog tick divider.
    always_comb begin
        tick = tick_cnt_q == 17'(WD_TICK_CYCLES_P - 1);
        tick_cnt_d = tick ? 17'h00000 : tick_cnt_q + 17'h00001;
    end

    // Option, watchdog and framing registers.
    always_comb begin
        opt_d = opt_q;
        wd_d = wd_q;
        frame_d = frame_q;
        if (tick && wd_q != 16'h0000) begin
            wd_d = wd_q - 16'h0001;
        end
        if (wr_fire && hit_opt) begin
            if (sel_i[0]) begin
                opt_d[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                opt_d[15:8] = dat_i[15:8];
            end
            opt_d = opt_d & OPT_USED_MASK;
        end
        if (wr_fire && hit_wd) begin
            if (sel_i[0]) begin
                wd_d[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
                wd_d[15:8] = dat_i[15:8];
            end
        end
        if (wr_fire && hit_frame) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    frame_d[b*8 +: 8] = dat_i[b*8 +: 8];
                end
            end
            frame_d = frame_d & {5'h00, FRAME_USED_MASK};
        end
        if (factory_reset_i) begin
            frame_d = FRAME_RESET;
            opt_d = OPT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_q <= OPT_RESET;
            wd_q <= WD_RESET;
            frame_q <= FRAME_RESET;
            tick_cnt_q <= 17'h00000;
        end else begin
            opt_q <= opt_d;
            wd_q <= wd_d;
            frame_q <= frame_d;
            tick_cnt_q <= tick_cnt_d;
        end
    end

    assign port1_baud_o = frame_q[FRAME_BAUD_LSB +: 16];
    assign port1_data_bits_o = frame_q[FRAME_DATA_LSB +: 4];
    assign port1_parity_o = frame_q[FRAME_PARITY_LSB +: 2];
    assign port1_stop_bits_o = frame_q[FRAME_STOP_LSB +: 2];
    assign port1_mode_o = port_mode_t'(frame_q[FRAME_MODE_LSB +: 3]);

    // Clear-to-send comes from a pin and is filtered before use.
    sync3 u_cts_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(cts_i),
        .level_o(cts_ok)
    );

    bit_swap #(
        .WIDTH(16)
    ) u_rack_swap (
        .swap_i(opt_q[OPT_SWAP_BIT]),
        .word_i(rack_in_i),
        .word_o(rack_mux)
    );

    // Auto-poll gating, rack handling and transmit path.
    always_comb begin
        poll_d[0] = ~opt_q[OPT_WD_PORT1_BIT] | (wd_q != 16'h0000);
        poll_d[1] = ~opt_q[OPT_WD_PORT2_BIT] | (wd_q != 16'h0000);
        zero_d = power_up_i & ~opt_q[OPT_RETAIN_BIT];
        rack_d = rack_mux;
        tx_d = cts_ok ? tx_i : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            poll_q <= 2'h3;
            zero_q <= 1'b0;
            rack_q <= 16'h0000;
            tx_q <= 1'b1;
        end else begin
            poll_q <= poll_d;
            zero_q <= zero_d;
            rack_q <= rack_d;
            tx_q <= tx_d;
        end
    end

    assign autopoll_en_o = poll_q;
    assign rack_zero_o = zero_q;
    assign rack_retain_o = opt_q[OPT_RETAIN_BIT];
    assign rack_out_o = rack_q;
    assign tx_o = tx_q;
    assign tx_allowed_o = cts_ok;

    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("ack missing one cycle after request");

    opt_reset_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> (opt_q == 16'h0000 && !rack_retain_o && autopoll_en_o == 2'h3))
        else $error("option bits not clear after reset");

    opt_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire && hit_opt && sel_i[1:0] == 2'h3 && !factory_reset_i)
        |=> opt_q == ($past(dat_i[15:0]) & 16'h0306))
        else $error("option write stored wrong bits");

    port1_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 autopoll_en_o[0] == (!$past(opt_q[1]) || $past(wd_q) != 16'h0000))
        else $error("port 1 auto-poll gating wrong");

    port2_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (opt_q[2] && wd_q == 16'h0000) |=> !autopoll_en_o[1])
        else $error("port 2 polls with expired watchdog");

    rack_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        power_up_i |=> (rack_zero_o == !$past(opt_q[8])))
        else $error("power-up zeroing disagrees with retain bit");

    rack_swap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 rack_out_o[0] == ($past(opt_q[9]) ? $past(rack_in_i[15]) : $past(rack_in_i[0])))
        else $error("rack word bit order wrong");

    cts_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !tx_o |-> $past(cts_ok))
        else $error("transmit without clear-to-send");

    factory_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
        factory_reset_i |=> (port1_baud_o == 16'h2580 && port1_data_bits_o == 4'h8
            && port1_parity_o == 2'h2 && port1_stop_bits_o == 2'h1
            && port1_mode_o == MODE_DUAL_SLAVE))
        else $error("factory framing wrong");

    wd_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_fire && hit_wd && sel_i[1:0] == 2'h3) |=> wd_q == $past(dat_i[15:0]))
        else $error("watchdog write not loaded");

    wd_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && wd_q != 16'h0000 && !(wr_fire && hit_wd)) |=> wd_q == $past(wd_q) - 16'h0001)
        else $error("watchdog count did not step down");

    read_opt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !we_i && !ack_o && hit_opt) |=> dat_o == {16'h0000, $past(opt_q)})
        else $error("option read data wrong");

    zero_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !power_up_i |=> !rack_zero_o)
        else $error("rack zeroing without power-up");

    tx_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cts_ok |=> tx_o == $past(tx_i))
        else $error("transmit data not passed with clear-to-send");

    tx_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cts_ok |=> tx_o)
        else $error("transmit line not idle without clear-to-send");

    port2_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !opt_q[2] |=> autopoll_en_o[1])
        else $error("port 2 gated with option clear");

    rack_msb_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 rack_out_o[15] == ($past(opt_q[9]) ? $past(rack_in_i[0]) : $past(rack_in_i[15])))
        else $error("rack word top bit order wrong");

    factory_opt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        factory_reset_i |=> opt_q == 16'h0000)
        else $error("options not cleared by factory reset");

    opt_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && hit_opt);
    retain_power_c: cover property (@(posedge clk_i) disable iff (rst_i)
        power_up_i && opt_q[8]);
    swap_on_c: cover property (@(posedge clk_i) disable iff (rst_i)
        opt_q[9] && rack_in_i[15]);
    cts_blocked_c: cover property (@(posedge clk_i) disable iff (rst_i)
        !cts_ok && !tx_i);
    factory_c: cover property (@(posedge clk_i) disable iff (rst_i)
        factory_reset_i);
endmodule

// ===== sim/wb_host_model.sv
`timescale 1ns/10ps
module wb_host_model (
    // Bus clock.
    input wire logic clk_i,
    // Wishbone classic master side.
    output logic [15:0] adr_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    output logic we_o,
    output logic [3:0] sel_o,
    output logic cyc_o,
    output logic stb_o,
    input wire logic ack_i
);
    initial begin
        adr_o = 16'h0000;
        dat_o = 32'h0000_0000;
        we_o = 1'b0;
        sel_o = 4'h0;
        cyc_o = 1'b0;
        stb_o = 1'b0;
    end

    // One classic cycle; the request is held until ack is sampled high.
    // Released lines show the inverse of their last value, not a stale copy.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        sel_o <= 4'hf;
        // Only ack or the bench timeout may end this wait.
        do begin
            @(posedge clk_i);
        end while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= ~w;
        adr_o <= ~a;
        dat_o <= ~d;
        sel_o <= 4'h0;
    endtask
endmodule

// ===== sim/global_options_register_bench.sv
`timescale 1ns/10ps
module global_options_register_bench;
    import gopt_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] adr;
    logic [31:0] wdat, rdat, q;
    logic we, cyc, stb, ack, rack_retain, rack_zero, tx, tx_ok;
    logic [3:0] sel, data_bits;
    logic [1:0] poll, parity, stop_bits;
    logic [15:0] rack_out, baud;
    port_mode_t mode;
    logic power_up = 1'b0, cts = 1'b0, tx_in = 1'b0, factory = 1'b0;
    logic [15:0] rack_in = 16'h0000;
    int bad_count = 0, checked = 0, cycles = 0;

    always #4 clk_i = ~clk_i;

    wb_host_model i_host (.clk_i(clk_i), .adr_o(adr), .dat_o(wdat), .dat_i(rdat), .we_o(we),
        .sel_o(sel), .cyc_o(cyc), .stb_o(stb), .ack_i(ack));

    global_options_register #(.WD_TICK_CYCLES_P(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc),
        .stb_i(stb), .ack_o(ack), .autopoll_en_o(poll), .power_up_i(power_up),
        .rack_retain_o(rack_retain), .rack_zero_o(rack_zero), .rack_in_i(rack_in),
        .rack_out_o(rack_out), .cts_i(cts), .tx_i(tx_in), .tx_o(tx), .tx_allowed_o(tx_ok),
        .factory_reset_i(factory), .port1_baud_o(baud), .port1_data_bits_o(data_bits),
        .port1_parity_o(parity), .port1_stop_bits_o(stop_bits), .port1_mode_o(mode));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_host.xfer(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        i_host.xfer(1'b0, a, 32'h0000_0000, d);
    endtask

    // Waits n edges, then lets that edge's updates settle before sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    function automatic logic [15:0] mirror(input logic [15:0] w);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) r[i] = w[15-i];
        return r;
    endfunction

    task automatic test_reset_values();
        tick(1);
        chk("poll", {30'h0, poll}, 32'h3);
        chk("framing", {8'h0, baud, data_bits, parity, stop_bits},
            {8'h0, 16'h2580, 4'h8, 2'h2, 2'h1});
        chk("mode", {29'h0, mode}, {29'h0, MODE_DUAL_SLAVE});
        rd(OPT_REG_ADDR, q);
        chk("opt", q, 32'h0);
        rd(FRAME_REG_ADDR, q);
        chk("frame_reg", q, FRAME_RESET);
        wr(OPT_REG_ADDR, 32'hffff_ffff);
        rd(OPT_REG_ADDR, q);
        chk("opt_reserved", q, 32'h0000_0306);
        wr(16'h0010, 32'h1234_5678);
        rd(16'h0010, q);
        chk("unmapped", q, 32'h0);
    endtask

    task automatic test_watchdog();
        wr(WD_REG_ADDR, 32'h0);
        wr(OPT_REG_ADDR, 32'h0002);
        tick(2);
        chk("poll_p1", {30'h0, poll}, 32'h2);
        wr(OPT_REG_ADDR, 32'h0006);
        tick(2);
        chk("poll_both", {30'h0, poll}, 32'h0);
        wr(WD_REG_ADDR, 32'h0003);
        tick(2);
        chk("poll_run", {30'h0, poll}, 32'h3);
        tick(20);
        chk("poll_expired", {30'h0, poll}, 32'h0);
    endtask

    task automatic test_rack();
        wr(OPT_REG_ADDR, 32'h0200);
        rack_in <= 16'h1234;
        tick(2);
        chk("rack_swap", {16'h0, rack_out}, {16'h0, mirror(16'h1234)});
        @(posedge clk_i);
        power_up <= 1'b1;
        @(posedge clk_i);
        power_up <= 1'b0;
        #1;
        chk("rack_zero", {31'h0, rack_zero}, 32'h1);
        wr(OPT_REG_ADDR, 32'h0100);
        rack_in <= 16'h1234;
        power_up <= 1'b1;
        @(posedge clk_i);
        power_up <= 1'b0;
        #1;
        chk("rack_kept", {14'h0, rack_zero, rack_retain, rack_out}, 32'h0001_1234);
    endtask

    task automatic test_cts();
        @(posedge clk_i);
        cts <= 1'b0;
        tx_in <= 1'b0;
        tick(6);
        chk("tx_blocked", {30'h0, tx_ok, tx}, 32'h1);
        @(posedge clk_i);
        cts <= 1'b1;
        tick(8);
        chk("tx_pass", {30'h0, tx_ok, tx}, 32'h2);
    endtask

    task automatic test_factory();
        wr(FRAME_REG_ADDR, 32'h0);
        tick(1);
        chk("mode_off", {29'h0, mode}, {29'h0, MODE_OFF});
        @(posedge clk_i);
        factory <= 1'b1;
        @(posedge clk_i);
        factory <= 1'b0;
        tick(1);
        chk("factory", {8'h0, baud, data_bits, parity, stop_bits},
            {8'h0, 16'h2580, 4'h8, 2'h2, 2'h1});
        chk("factory_mode", {29'h0, mode}, {29'h0, MODE_DUAL_SLAVE});
        rd(OPT_REG_ADDR, q);
        chk("factory_opt", q, 32'h0);
        // A reset in mid-run must clear every option again.
        wr(OPT_REG_ADDR, 32'h0000_0306);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OPT_REG_ADDR, q);
        chk("opt_after_reset", q, 32'h0);
        chk("poll_after_reset", {30'h0, poll}, 32'h3);
        chk("retain_after_reset", {31'h0, rack_retain}, 32'h0);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_values();
        test_watchdog();
        test_rack();
        test_cts();
        test_factory();
        summarize();
    end
endmodule
